// *** logic/bpit_map.svh ***
// Named offsets, divisor counts, field positions and reset values of the parallel I/O,
// interrupt mask and rate generator block.
// Assumes nothing; holds definitions only and is included by bare name.
`ifndef BPIT_MAP_SVH
`define BPIT_MAP_SVH

// Reference clock and the slower system clock the rate chain is specified against.
`define BPIT_REF_HZ 200000000
`define BPIT_SYS_HZ 2000000
`define BPIT_PRESCALE (`BPIT_REF_HZ / `BPIT_SYS_HZ)

// Divider ratios of the rate chain.
`define BPIT_DIV_9600 13
`define BPIT_DIV_HALF 2
`define BPIT_DIV_110 22
`define BPIT_DIV_TICK 16
`define BPIT_DIV_TICK_HALF 2
`define BPIT_DIV_W 7

// Rate chain taps: index 0 is 9600 baud, each next index up to 6 halves it, the last is 110 baud.
`define BPIT_NUM_RATES 8
`define BPIT_RATE_2400 3'h2
`define BPIT_RATE_110 3'h7
`define BPIT_NUM_SERIAL 3

// Low address digit of each parallel channel; the high digit is a board strap.
`define BPIT_ADDR_A_LO 4'h8
`define BPIT_ADDR_B_LO 4'h9

// Channel A output latch bit positions used as interrupt masks.
`define BPIT_MASK_RX_LSB 0
`define BPIT_MASK_TX_LSB 3
`define BPIT_MASK_TICK_BIT 6
`define BPIT_NUM_SRC 7

// Acknowledge bit select: values with this bit set select no bit.
`define BPIT_ACK_NONE_BIT 3

// Reset and idle values.
`define BPIT_RST_LATCH 8'h00
`define BPIT_BUS_IDLE 8'hFF
`define BPIT_BUS_DRIVE 8'hFF
`define BPIT_BUS_FLOAT 8'h00

`endif

// *** logic/bpit_pkg.sv ***
// Types shared by the parallel I/O block and its divider stage.
// Assumes bpit_map.svh is on the include path.
`include "bpit_map.svh"

package bpit_pkg;

   // Rate chain tap selection of one serial channel.
   typedef enum logic [2:0] {
      BPIT_R9600 = 3'h0,
      BPIT_R4800 = 3'h1,
      BPIT_R2400 = 3'h2,
      BPIT_R1200 = 3'h3,
      BPIT_R600 = 3'h4,
      BPIT_R300 = 3'h5,
      BPIT_R150 = 3'h6,
      BPIT_R110 = 3'h7
   } bpit_rate_t;

   // State of one divider stage.
   typedef struct packed {
      logic [`BPIT_DIV_W-1:0] cnt;
   } bpit_div_state_t;

   // State of the top block.
   typedef struct packed {
      logic [7:0] out_a;
      logic [7:0] out_b;
      logic tick_req;
      logic [7:0] din;
      logic [7:0] din_oe;
      logic pint_oe;
      logic [`BPIT_NUM_SERIAL-1:0] bit_clk;
   } bpit_state_t;

endpackage : bpit_pkg

// *** logic/bpit_div.sv ***
// One synchronous divide-by-N stage driven by a single-cycle enable.
// Assumes the enable is a one-cycle pulse in the ref_clk domain.
`timescale 1ns/1ps
`include "bpit_map.svh"

module bpit_div #(
   parameter int N = 2
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Count enable and terminal count.
   input wire logic en,
   output logic tc
);

   bpit_pkg::bpit_div_state_t s_q;
   bpit_pkg::bpit_div_state_t s_d;
   logic last;

   assign last = (s_q.cnt == `BPIT_DIV_W'(N - 1));
   // Gating by the enable keeps the terminal count a single-cycle pulse.
   assign tc = en && last;

   always_comb begin
      s_d = s_q;
      if (en) begin
         s_d.cnt = last ? '0 : s_q.cnt + `BPIT_DIV_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : bpit_div

// *** logic/bpit_top.sv ***
// Parallel I/O ports, interrupt masking, periodic tick and serial rate generator.
// Assumes host bus strobes are synchronous to ref_clk and the serial flags come from
// controllers outside this block; the host resolves wired levels from the enables.
//
// Contract
// - Input path passes lines through unheld; output path holds the last written byte.
// - Reading channel B clears the latched periodic tick request.
// - A strap moves the tick clear from the channel B read to channel A.
// - Bit-rate clocks come from the 2 MHz clock at sixteen times baud.
// - The 9600-baud clock is one gated pulse per thirteen system clocks.
// - Lower rates except 110 come from repeated halving of the 9600 clock.
// - The 110-baud clock is the 2400-baud clock divided by twenty-two.
// - Each serial channel has a static rate select feeding both bit clocks.
// - Input access needs address match, input cycle and data-in strobe; per channel.
// - Input byte drives the bus only while the channel input enable is active.
// - Output write needs address match, output cycle and low write strobe.
// - Write strobe captures the data bus; the latch holds until the next write.
// - Each ready flag reaches the interrupt only while its channel A bit is one.
// - Enabled sources form an active-low wired OR that is only ever pulled low.
// - The tick is the 110-baud clock divided by sixteen and then by two.
// - Each tick sets a sticky request, cleared by the port read, maskable.
// - Channel A sits at address x8 and channel B at x9.
// - During acknowledge with interrupt pending, one chosen data-in bit is pulled low.
`timescale 1ns/1ps
`include "bpit_map.svh"

module bpit_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Board straps.
   input wire logic [3:0] addr_hi,
   input wire logic tick_clr_on_a,
   input wire logic [3:0] ack_bit_sel,
   input wire logic [2:0] rate_sel_0,
   input wire logic [2:0] rate_sel_1,
   input wire logic [2:0] rate_sel_2,
   // Host bus.
   input wire logic [7:0] addr,
   input wire logic sinp,
   input wire logic sout,
   input wire logic pdbin,
   input wire logic pwr_b,
   input wire logic sinta,
   input wire logic [7:0] dout,
   output logic [7:0] din,
   output logic [7:0] din_oe,
   // Interrupt line, open drain.
   output logic pint_b_o,
   output logic pint_b_oe,
   // Parallel connector lines.
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_b_out,
   // Serial controllers.
   input wire logic [`BPIT_NUM_SERIAL-1:0] serial_tx_ready_flag,
   input wire logic [`BPIT_NUM_SERIAL-1:0] serial_rx_ready_flag,
   output logic [`BPIT_NUM_SERIAL-1:0] transmit_bit_clock,
   output logic [`BPIT_NUM_SERIAL-1:0] receive_bit_clock
);

   ////////////////////////////////////////////////////////////////////////////////////////

   bpit_pkg::bpit_state_t s_q;
   bpit_pkg::bpit_state_t s_d;

   logic sys_en;
   logic [`BPIT_NUM_RATES-1:0] rate_tc;
   logic tick_16;
   logic tick_pulse;
   logic [7:0] addr_a;
   logic [7:0] addr_b;
   logic rd_a;
   logic rd_b;
   logic wr_a;
   logic wr_b;
   logic tick_clr;
   logic ack_pull;
   logic [`BPIT_NUM_SRC-1:0] irq_src;
   logic [`BPIT_NUM_SRC-1:0] irq_en;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Rate chain. Every stage runs on ref_clk; each one after the free-running prescaler advances on an earlier stage's pulse,
   // so no derived clock ever reaches a flip-flop clock pin.

   bpit_div #(.N(`BPIT_PRESCALE)) u_sys_div (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(1'b1),
      .tc(sys_en)
   );

   bpit_div #(.N(`BPIT_DIV_9600)) u_div_9600 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(sys_en),
      .tc(rate_tc[0])
   );

   for (genvar g = 1; g < `BPIT_NUM_RATES - 1; g++) begin : g_half
      bpit_div #(.N(`BPIT_DIV_HALF)) u_half (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .en(rate_tc[g-1]),
         .tc(rate_tc[g])
      );
   end

   bpit_div #(.N(`BPIT_DIV_110)) u_div_110 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(rate_tc[`BPIT_RATE_2400]),
      .tc(rate_tc[`BPIT_RATE_110])
   );

   bpit_div #(.N(`BPIT_DIV_TICK)) u_tick_16 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(rate_tc[`BPIT_RATE_110]),
      .tc(tick_16)
   );

   bpit_div #(.N(`BPIT_DIV_TICK_HALF)) u_tick_2 (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(tick_16),
      .tc(tick_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Address decode.

   assign addr_a = {addr_hi, `BPIT_ADDR_A_LO};
   assign addr_b = {addr_hi, `BPIT_ADDR_B_LO};
   assign rd_a = (addr == addr_a) && sinp && pdbin;
   assign rd_b = (addr == addr_b) && sinp && pdbin;
   assign wr_a = (addr == addr_a) && sout && !pwr_b;
   assign wr_b = (addr == addr_b) && sout && !pwr_b;
   assign tick_clr = tick_clr_on_a ? rd_a : rd_b;

   // The response byte is only touched when this board itself is pulling the line.
   assign ack_pull = sinta && s_q.pint_oe && !ack_bit_sel[`BPIT_ACK_NONE_BIT];

   assign irq_src[`BPIT_MASK_RX_LSB +: `BPIT_NUM_SERIAL] = serial_rx_ready_flag;
   assign irq_src[`BPIT_MASK_TX_LSB +: `BPIT_NUM_SERIAL] = serial_tx_ready_flag;
   assign irq_src[`BPIT_MASK_TICK_BIT] = s_q.tick_req;
   assign irq_en = irq_src & s_q.out_a[`BPIT_NUM_SRC-1:0];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      s_d = s_q;
      if (wr_a) begin
         s_d.out_a = dout;
      end
      if (wr_b) begin
         s_d.out_b = dout;
      end
      // A tick landing in the clearing cycle wins, so no tick is lost.
      if (tick_pulse) begin
         s_d.tick_req = 1'b1;
      end else if (tick_clr) begin
         s_d.tick_req = 1'b0;
      end
      s_d.din = `BPIT_BUS_IDLE;
      s_d.din_oe = `BPIT_BUS_FLOAT;
      if (rd_a) begin
         s_d.din = port_a_in;
         s_d.din_oe = `BPIT_BUS_DRIVE;
      end else if (rd_b) begin
         s_d.din = port_b_in;
         s_d.din_oe = `BPIT_BUS_DRIVE;
      end else if (ack_pull) begin
         s_d.din[ack_bit_sel[2:0]] = 1'b0;
         s_d.din_oe[ack_bit_sel[2:0]] = 1'b1;
      end
      s_d.pint_oe = |irq_en;
      s_d.bit_clk[0] = rate_tc[rate_sel_0];
      s_d.bit_clk[1] = rate_tc[rate_sel_1];
      s_d.bit_clk[2] = rate_tc[rate_sel_2];
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q.out_a <= `BPIT_RST_LATCH;
         s_q.out_b <= `BPIT_RST_LATCH;
         s_q.tick_req <= 1'b0;
         s_q.din <= `BPIT_BUS_IDLE;
         s_q.din_oe <= `BPIT_BUS_FLOAT;
         s_q.pint_oe <= 1'b0;
         s_q.bit_clk <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs. The interrupt line is never driven high; the host pulls it up.

   assign din = s_q.din;
   assign din_oe = s_q.din_oe;
   assign pint_b_o = 1'b0;
   assign pint_b_oe = s_q.pint_oe;
   assign port_a_out = s_q.out_a;
   assign port_b_out = s_q.out_b;
   // Both bit clocks of a channel share one tap, so receive and transmit rates match.
   assign transmit_bit_clock = s_q.bit_clk;
   assign receive_bit_clock = s_q.bit_clk;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   localparam int GAP_9600 = `BPIT_PRESCALE * `BPIT_DIV_9600;
   localparam int GAP_110 = GAP_9600 * `BPIT_DIV_HALF * `BPIT_DIV_HALF * `BPIT_DIV_110;
   logic [31:0] gap_9600_q;
   logic seen_9600_q;
   logic [31:0] gap_110_q;
   logic seen_110_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_9600_q <= '0;
         seen_9600_q <= 1'b0;
         gap_110_q <= '0;
         seen_110_q <= 1'b0;
      end else begin
         gap_9600_q <= rate_tc[0] ? '0 : gap_9600_q + 32'h1;
         seen_9600_q <= seen_9600_q || rate_tc[0];
         gap_110_q <= rate_tc[`BPIT_RATE_110] ? '0 : gap_110_q + 32'h1;
         seen_110_q <= seen_110_q || rate_tc[`BPIT_RATE_110];
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   a_rate_9600_gap: assert property (
      rate_tc[0] && seen_9600_q |-> gap_9600_q == 32'(GAP_9600 - 1))
      else $error("9600 tap spacing wrong");

   a_rate_110_gap: assert property (
      rate_tc[`BPIT_RATE_110] && seen_110_q |-> gap_110_q == 32'(GAP_110 - 1))
      else $error("110 tap spacing wrong");

   a_rate_half_sub: assert property (
      rate_tc[1] |-> rate_tc[0])
      else $error("halved tap without parent pulse");

   a_bit_clk_route: assert property (
      rate_tc[rate_sel_1] && $stable(rate_sel_1) |=> transmit_bit_clock[1]
      && receive_bit_clock[1])
      else $error("bit clock not routed from selected tap");

   a_tick_set: assert property (
      tick_pulse |=> s_q.tick_req ##1 s_q.tick_req || $past(tick_clr))
      else $error("tick request not set");

   a_tick_clear: assert property (
      tick_clr && !tick_pulse |=> !s_q.tick_req)
      else $error("port read did not clear tick request");

   a_tick_opt: assert property (
      tick_clr_on_a && rd_b && !rd_a && s_q.tick_req && !tick_pulse |=> s_q.tick_req)
      else $error("channel B read cleared tick with option moved");

   a_write_latch: assert property (
      wr_a |=> port_a_out == $past(dout) ##1 ($past(wr_a) || port_a_out == $past(dout, 2)))
      else $error("channel A latch wrong");

   a_read_drive: assert property (
      rd_b && !rd_a |=> din_oe == `BPIT_BUS_DRIVE && din == $past(port_b_in))
      else $error("channel B read not driven");

   a_bus_float: assert property (
      !rd_a && !rd_b && !ack_pull |=> din_oe == `BPIT_BUS_FLOAT)
      else $error("bus driven while idle");

   a_irq_mask: assert property (
      |(irq_src & s_q.out_a[`BPIT_NUM_SRC-1:0]) |=> pint_b_oe && !pint_b_o)
      else $error("unmasked source did not pull interrupt");

   a_irq_quiet: assert property (
      s_q.out_a == `BPIT_RST_LATCH |=> !pint_b_oe)
      else $error("interrupt pulled while all masked");

   a_ack_bit: assert property (
      ack_pull && !rd_a && !rd_b |=> din_oe == (8'h01 << $past(ack_bit_sel[2:0]))
      && din == ~(8'h01 << $past(ack_bit_sel[2:0])))
      else $error("acknowledge byte wrong");

   a_read_a_drive: assert property (
      rd_a |=> din_oe == `BPIT_BUS_DRIVE && din == $past(port_a_in))
      else $error("channel A read not driven");

   a_write_b_latch: assert property (
      wr_b |=> port_b_out == $past(dout))
      else $error("channel B latch wrong");

   // Checked on channel B, whose latch no interrupt logic ever touches.
   a_latch_hold: assert property (
      !wr_b |=> $stable(port_b_out))
      else $error("channel B latch moved without a write");

   a_tick_opt_a: assert property (
      tick_clr_on_a && rd_a && !tick_pulse |=> !s_q.tick_req)
      else $error("channel A read did not clear tick with option moved");

   a_ack_none: assert property (
      ack_bit_sel[`BPIT_ACK_NONE_BIT] && !rd_a && !rd_b |=> din_oe == `BPIT_BUS_FLOAT)
      else $error("acknowledge drove a bit with no bit selected");

   a_irq_masked: assert property (
      (irq_src & s_q.out_a[`BPIT_NUM_SRC-1:0]) == '0 |=> !pint_b_oe)
      else $error("interrupt pulled with every source masked");

   a_sys_base: assert property (
      rate_tc[0] |-> sys_en)
      else $error("9600 tap off the system clock enable");

   a_rate_half_lo: assert property (
      rate_tc[`BPIT_RATE_2400] |-> rate_tc[1])
      else $error("2400 tap without 4800 pulse");

   a_rate_110_sub: assert property (
      rate_tc[`BPIT_RATE_110] |-> rate_tc[`BPIT_RATE_2400])
      else $error("110 tap without 2400 pulse");

   a_tick_sub: assert property (
      tick_pulse |-> tick_16 && rate_tc[`BPIT_RATE_110])
      else $error("tick without its parent pulses");

   a_bit_clk_quiet: assert property (
      !rate_tc[rate_sel_0] && $stable(rate_sel_0) |=> !transmit_bit_clock[0])
      else $error("bit clock pulsed without its tap");

   c_tick_cleared: cover property (s_q.tick_req ##1 tick_clr ##1 !s_q.tick_req);
   c_masked_irq: cover property (wr_a ##[1:8] pint_b_oe);
   c_ack_cycle: cover property (ack_pull ##1 din_oe != `BPIT_BUS_FLOAT);
   c_read_a: cover property (rd_a ##1 din_oe == `BPIT_BUS_DRIVE);

endmodule : bpit_top

// *** bench/bpit_host.sv ***
// Host bus model for the parallel I/O block: drives the bus strobes and resolves wired lines.
// Assumes one clock, ref_clk, and a block that registers its answers on the rising edge.
`timescale 1ns/1ps

module bpit_host (
   // Clock.
   input wire logic ref_clk,
   // Lines driven by the block.
   input wire logic [7:0] din,
   input wire logic [7:0] din_oe,
   input wire logic pint_b_o,
   input wire logic pint_b_oe,
   // Bus lines driven by the host.
   output logic [7:0] addr,
   output logic sinp,
   output logic sout,
   output logic pdbin,
   output logic pwr_b,
   output logic sinta,
   output logic [7:0] dout,
   // Resolved wired lines.
   output logic [7:0] bus_in,
   output logic pint_line
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Both lines carry pull-ups, so an undriven bit always reads as one.
   assign bus_in = (din & din_oe) | ~din_oe;
   assign pint_line = ~(pint_b_oe & ~pint_b_o);

   initial begin
      addr = 8'h00;
      sinp = 1'b0;
      sout = 1'b0;
      pdbin = 1'b0;
      pwr_b = 1'b1;
      sinta = 1'b0;
      dout = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse of the last value, so a stale capture cannot pass.
   task io_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      dout <= d;
      sout <= 1'b1;
      pwr_b <= 1'b0;
      @(posedge ref_clk);
      sout <= 1'b0;
      pwr_b <= 1'b1;
      addr <= ~a;
      dout <= ~d;
      #1;
   endtask : io_wr

   task io_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      sinp <= 1'b1;
      pdbin <= 1'b1;
      @(posedge ref_clk);
      sinp <= 1'b0;
      pdbin <= 1'b0;
      addr <= ~a;
      #1;
      d = bus_in;
   endtask : io_rd

   task set_ack(input logic on);
      @(posedge ref_clk);
      sinta <= on;
   endtask : set_ack

endmodule : bpit_host

// *** bench/testbench.sv ***
// Self-checking bench for the parallel I/O, interrupt mask and rate generator block.
// Assumes the host model drives the bus; straps, connector lines and flags come from here.
`timescale 1ns/1ps
`include "bpit_map.svh"

module testbench;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic tick_clr_on_a = 1'b0;
   logic [3:0] ack_bit_sel = 4'hF;
   logic [7:0] port_a_in = 8'h3C;
   logic [7:0] port_b_in = 8'hC3;
   logic [2:0] tx_flag = 3'h0;
   logic [2:0] rx_flag = 3'h0;
   logic [3:0] addr_hi = 4'h3;
   logic [2:0] rate_sel_0 = 3'h0;
   logic [2:0] rate_sel_1 = 3'h1;
   logic [2:0] rate_sel_2 = 3'h3;
   logic [7:0] addr, dout, din, din_oe, port_a_out, port_b_out, bus_in, d;
   logic sinp, sout, pdbin, pwr_b, sinta, pint_b_o, pint_b_oe, pint_line;
   logic [2:0] tx_clk, rx_clk;
   logic [31:0] cnt, bad;
   int n_errors = 0;
   int n_tests = 0;
   // The upper address digit is strapped away from zero so a stuck digit shows.
   localparam logic [7:0] ADR_A = {4'h3, `BPIT_ADDR_A_LO};
   localparam logic [7:0] ADR_B = {4'h3, `BPIT_ADDR_B_LO};

   always #2.5 ref_clk = ~ref_clk;

   bpit_top u_bpit_top (.ref_clk(ref_clk), .rst_b(rst_b), .addr_hi(addr_hi),
      .tick_clr_on_a(tick_clr_on_a), .ack_bit_sel(ack_bit_sel), .rate_sel_0(rate_sel_0),
      .rate_sel_1(rate_sel_1), .rate_sel_2(rate_sel_2), .addr(addr), .sinp(sinp), .sout(sout),
      .pdbin(pdbin), .pwr_b(pwr_b), .sinta(sinta), .dout(dout), .din(din), .din_oe(din_oe),
      .pint_b_o(pint_b_o), .pint_b_oe(pint_b_oe), .port_a_in(port_a_in),
      .port_b_in(port_b_in), .port_a_out(port_a_out), .port_b_out(port_b_out),
      .serial_tx_ready_flag(tx_flag), .serial_rx_ready_flag(rx_flag),
      .transmit_bit_clock(tx_clk), .receive_bit_clock(rx_clk));

   bpit_host u_bpit_host (.ref_clk(ref_clk), .din(din), .din_oe(din_oe), .pint_b_o(pint_b_o),
      .pint_b_oe(pint_b_oe), .addr(addr), .sinp(sinp), .sout(sout), .pdbin(pdbin),
      .pwr_b(pwr_b), .sinta(sinta), .dout(dout), .bus_in(bus_in), .pint_line(pint_line));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      if (n_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   // Edges from one bit clock pulse to the next; both bit clocks must agree every cycle.
   task measure(input int ch);
      do begin
         @(posedge ref_clk);
         #1;
      end while (tx_clk[ch] !== 1'b1);
      cnt = 0;
      do begin
         @(posedge ref_clk);
         #1;
         cnt++;
         if (rx_clk[ch] !== tx_clk[ch]) bad++;
      end while (tx_clk[ch] !== 1'b1 && cnt < 32'h0000_9C40);
   endtask : measure

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1;
      check(port_a_out, 8'h00);
      check(port_b_out, 8'h00);
      check(pint_line, 1'b1);
      check(bus_in, 8'hFF);
      u_bpit_host.io_wr(ADR_A, 8'h5A);
      u_bpit_host.io_wr(ADR_B, 8'hA5);
      check(port_a_out, 8'h5A);
      check(port_b_out, 8'hA5);
      u_bpit_host.io_wr({4'h4, `BPIT_ADDR_A_LO}, 8'hFF);
      u_bpit_host.io_wr(8'h3A, 8'h00);
      check({port_a_out, port_b_out}, 16'h5AA5);
      u_bpit_host.io_rd(ADR_A, d);
      check(d, 8'h3C);
      u_bpit_host.io_rd(ADR_B, d);
      check(d, 8'hC3);
      @(posedge ref_clk);
      port_b_in <= 8'h81;
      u_bpit_host.io_rd(ADR_B, d);
      check(d, 8'h81);
      check(port_b_out, 8'hA5);
      u_bpit_host.io_rd(8'h3A, d);
      check(d, 8'hFF);
      u_bpit_host.io_rd({4'h4, `BPIT_ADDR_B_LO}, d);
      check(d, 8'hFF);
      @(posedge ref_clk);
      tick_clr_on_a <= 1'b1;
      addr_hi <= 4'h4;
      u_bpit_host.io_rd({4'h4, `BPIT_ADDR_A_LO}, d);
      check(d, 8'h3C);
      u_bpit_host.io_wr({4'h4, `BPIT_ADDR_A_LO}, 8'h66);
      check(port_a_out, 8'h66);
      @(posedge ref_clk);
      tick_clr_on_a <= 1'b0;
      addr_hi <= 4'h3;
      // Each ready flag in turn: open only its mask bit, then every other ready flag mask bit, with the tick bit kept closed.
      for (int s = 0; s < 6; s++) begin
         u_bpit_host.io_wr(ADR_A, 8'h01 << s);
         @(posedge ref_clk);
         if (s < 3) rx_flag <= 3'h1 << s;
         else tx_flag <= 3'h1 << (s - 3);
         repeat (2) @(posedge ref_clk);
         #1;
         check(pint_line, 1'b0);
         check(pint_b_o, 1'b0);
         u_bpit_host.io_wr(ADR_A, ~(8'h01 << s) & 8'h3F);
         repeat (2) @(posedge ref_clk);
         #1;
         check(pint_line, 1'b1);
         @(posedge ref_clk);
         rx_flag <= 3'h0;
         tx_flag <= 3'h0;
      end
      u_bpit_host.io_wr(ADR_A, 8'h01);
      @(posedge ref_clk);
      rx_flag <= 3'h1;
      u_bpit_host.set_ack(1'b1);
      for (int b = 0; b < 9; b++) begin
         @(posedge ref_clk);
         ack_bit_sel <= b[3:0];
         repeat (2) @(posedge ref_clk);
         #1;
         check(bus_in, ~(16'h0001 << b) & 16'h00FF);
      end
      @(posedge ref_clk);
      ack_bit_sel <= 4'h2;
      rx_flag <= 3'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      check(bus_in, 8'hFF);
      u_bpit_host.set_ack(1'b0);
      bad = 0;
      measure(0);
      check(cnt, `BPIT_PRESCALE * `BPIT_DIV_9600);
      measure(1);
      check(cnt, `BPIT_PRESCALE * `BPIT_DIV_9600 * 2);
      measure(2);
      check(cnt, `BPIT_PRESCALE * `BPIT_DIV_9600 * 8);
      check(bad, 32'h0000_0000);
      complete_run;
   end

   // The whole sequence needs under 30k cycles; this limit allows twice that.
   initial begin
      #300000;
      n_errors++;
      complete_run;
   end

endmodule : testbench
